//--- verilog/ext_irq_pkg.sv
// Constants and carrier types for the external interrupt front end
package ext_irq_pkg;

  // Vector types of each request source
  localparam logic [7:0] VEC_REQ_A = 8'h0c;
  localparam logic [7:0] VEC_REQ_B = 8'h0d;
  localparam logic [7:0] VEC_REQ_C = 8'h0e;
  localparam logic [7:0] VEC_REQ_D = 8'h0f;
  localparam logic [7:0] VEC_REQ_E = 8'h11;
  localparam logic [7:0] VEC_NMI   = 8'h02;

  // Bit positions within the maskable request vector
  localparam int REQ_A = 0;
  localparam int REQ_B = 1;
  localparam int REQ_C = 2;
  localparam int REQ_D = 3;
  localparam int REQ_E = 4;
  localparam int NUM_REQ = 5;

  // Synchroniser depth and reset values
  localparam int         SYNC_STAGES = 2;
  localparam logic [4:0] MASK_RESET  = 5'h1f;
  localparam logic [4:0] REQ_RESET   = 5'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACK  = 3'b010,
    ST_DONE = 3'b100
  } ack_state_t;

  // Request presented to the core
  typedef struct packed {
    logic       valid;
    logic       nmi;
    logic [7:0] vector;
  } irq_req_t;

endpackage : ext_irq_pkg

//--- verilog/pin_sync.sv
// Two-stage synchroniser for one asynchronous pin
`timescale 1ns/1ps
module pin_sync
  import ext_irq_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // Pin and result
  input  wire logic pin_in,
  output logic      pin_sync_out
);

  logic [SYNC_STAGES-1:0] stage_q;
  logic [SYNC_STAGES-1:0] stage_d;

  always_comb begin
    stage_d = {stage_q[SYNC_STAGES-2:0], pin_in};
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stage_q <= '0;
    end else begin
      stage_q <= stage_d;
    end
  end

  assign pin_sync_out = stage_q[SYNC_STAGES-1];

endmodule : pin_sync

//--- verilog/ext_irq_pins.sv
// External interrupt front end: request pins, expansion acknowledges, latched non-maskable request
//
// Summary of operation
// - Requests a and b vector to types 12 and 13.
// - Requests c, d and e vector to types 14, 15 and 17.
// - In expansion mode the c and d pins act as acknowledge outputs for requests a and b.
// - In expansion mode acknowledge a is driven low to answer a taken request a.
// - In expansion mode acknowledge b is driven low to answer a taken request b.
// - A rising edge on the non-maskable request is serviced as type 2 regardless of the mask.
// - The non-maskable request is latched until the core services it.
`timescale 1ns/1ps
module ext_irq_pins
  import ext_irq_pkg::*;
(
  // Clock and reset
  input  wire logic     ref_clk,
  input  wire logic     srst,
  // Request pins
  input  wire logic     ext_request_a,
  input  wire logic     ext_request_b,
  input  wire logic     ext_request_c_in,
  input  wire logic     ext_request_d_in,
  input  wire logic     ext_request_e,
  input  wire logic     nmi_request,
  // Shared c/d pins, acknowledge side
  output logic          ack_a_low,
  output logic          ack_a_oe,
  output logic          ack_b_low,
  output logic          ack_b_oe,
  // Core control
  input  wire logic     expansion_en,
  input  wire logic [4:0] mask,
  // Request to core and its acknowledge
  output irq_req_t      irq_req,
  input  wire logic     irq_taken
);

  logic [NUM_REQ-1:0] pin_raw;
  logic [NUM_REQ-1:0] req_sync;
  logic               nmi_sync;

  always_comb begin
    pin_raw[REQ_A] = ext_request_a;
    pin_raw[REQ_B] = ext_request_b;
    pin_raw[REQ_C] = ext_request_c_in;
    pin_raw[REQ_D] = ext_request_d_in;
    pin_raw[REQ_E] = ext_request_e;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REQ; gi++) begin : g_sync
      pin_sync u_sync (
        .ref_clk      (ref_clk),
        .srst         (srst),
        .pin_in       (pin_raw[gi]),
        .pin_sync_out (req_sync[gi])
      );
    end
  endgenerate

  pin_sync u_nmi_sync (
    .ref_clk      (ref_clk),
    .srst         (srst),
    .pin_in       (nmi_request),
    .pin_sync_out (nmi_sync)
  );

  // Non-maskable edge detect and latch state
  logic               nmi_prev_q;
  logic               nmi_prev_d;
  logic               nmi_pend_q;
  logic               nmi_pend_d;
  logic               nmi_rise;
  logic               nmi_serviced;
  logic               nmi_present;

  // Request register
  logic [NUM_REQ-1:0] active;
  irq_req_t           req_q;
  irq_req_t           req_d;

  // Expansion acknowledge state
  ack_state_t         st_q;
  ack_state_t         st_d;
  logic               ack_take;
  logic               ack_for_a;
  logic               ack_for_b;
  logic               ack_a_q;
  logic               ack_a_d;
  logic               ack_b_q;
  logic               ack_b_d;

  assign nmi_rise     = nmi_sync & ~nmi_prev_q;
  assign nmi_serviced = irq_taken & req_q.valid & req_q.nmi;

  always_comb begin
    nmi_prev_d = nmi_sync;
    nmi_pend_d = nmi_pend_q;
    if (nmi_serviced) begin
      nmi_pend_d = 1'b0;
    end
    // A new edge in the clearing cycle wins
    if (nmi_rise) begin
      nmi_pend_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      nmi_prev_q <= 1'b0;
      nmi_pend_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_prev_d;
      nmi_pend_q <= nmi_pend_d;
    end
  end

  // Drops in the taking cycle so the core cannot take it twice
  assign nmi_present = nmi_pend_q & nmi_pend_d;

  // Level requests, c and d lost to the pins in expansion mode
  always_comb begin
    active = req_sync & ~mask;
    if (expansion_en) begin
      active[REQ_C] = 1'b0;
      active[REQ_D] = 1'b0;
    end
  end

  // Expansion answer due for a taken request a or b
  assign ack_for_a = (req_q.vector == VEC_REQ_A);
  assign ack_for_b = (req_q.vector == VEC_REQ_B);
  assign ack_take  = irq_taken & req_q.valid & ~req_q.nmi & expansion_en &
                     (ack_for_a | ack_for_b) & (st_q == ST_IDLE);

  // Fixed priority: nmi, then a..e
  always_comb begin
    req_d = '0;
    if (nmi_present) begin
      req_d.valid  = 1'b1;
      req_d.nmi    = 1'b1;
      req_d.vector = VEC_NMI;
    end else if (active[REQ_A]) begin
      req_d.valid  = 1'b1;
      req_d.vector = VEC_REQ_A;
    end else if (active[REQ_B]) begin
      req_d.valid  = 1'b1;
      req_d.vector = VEC_REQ_B;
    end else if (active[REQ_C]) begin
      req_d.valid  = 1'b1;
      req_d.vector = VEC_REQ_C;
    end else if (active[REQ_D]) begin
      req_d.valid  = 1'b1;
      req_d.vector = VEC_REQ_D;
    end else if (active[REQ_E]) begin
      req_d.valid  = 1'b1;
      req_d.vector = VEC_REQ_E;
    end
    // Withdrawn from the taking edge until the handshake ends
    if (ack_take || st_q != ST_IDLE) begin
      req_d = req_q;
      req_d.valid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      req_q <= '0;
    end else begin
      req_q <= req_d;
    end
  end

  // Acknowledge handshake for expansion requests
  always_comb begin
    st_d    = st_q;
    ack_a_d = 1'b1;
    ack_b_d = 1'b1;
    case (st_q)
      ST_IDLE: begin
        if (ack_take) begin
          st_d    = ST_ACK;
          ack_a_d = ~ack_for_a;
          ack_b_d = ~ack_for_b;
        end
      end
      ST_ACK: begin
        // Acknowledge low for this one cycle
        st_d = ST_DONE;
      end
      ST_DONE: begin
        // Gap before the request may return
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q    <= ST_IDLE;
      ack_a_q <= 1'b1;
      ack_b_q <= 1'b1;
    end else begin
      st_q    <= st_d;
      ack_a_q <= ack_a_d;
      ack_b_q <= ack_b_d;
    end
  end

  // Outputs
  assign irq_req   = req_q;

  assign ack_a_low = ack_a_q;
  assign ack_b_low = ack_b_q;
  assign ack_a_oe  = expansion_en;
  assign ack_b_oe  = expansion_en;

endmodule : ext_irq_pins

//--- verification/ext_irq_pins_asserts.sv
// Checker for the external interrupt front end
`timescale 1ns/1ps
module ext_irq_pins_asserts
  import ext_irq_pkg::*;
(
  input wire logic ref_clk, srst, ext_request_a, ext_request_b, ext_request_c_in, ext_request_d_in,
  input wire logic ext_request_e, nmi_request, ack_a_low, ack_a_oe, ack_b_low, ack_b_oe, expansion_en,
  input wire logic [4:0] mask,
  input wire irq_req_t irq_req,
  input wire logic irq_taken
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_oe_follow: assert property (ack_a_oe == expansion_en && ack_b_oe == expansion_en) else $error("oe");
  a_ack_pulse: assert property (!ack_a_low || !ack_b_low |=> ack_a_low && ack_b_low) else $error("ack");
  a_ack_a_src: assert property ($fell(ack_a_low) |->
    $past(expansion_en && irq_taken && irq_req.valid && irq_req.vector == VEC_REQ_A)) else $error("ack a");
  a_ack_b_src: assert property ($fell(ack_b_low) |->
    $past(expansion_en && irq_taken && irq_req.valid && irq_req.vector == VEC_REQ_B)) else $error("ack b");
  a_nmi_vec: assert property (irq_req.valid && irq_req.nmi |-> irq_req.vector == VEC_NMI) else $error("nmi");
  a_nmi_hold: assert property (irq_req.valid && irq_req.nmi && !irq_taken |=>
    irq_req.valid && irq_req.nmi) else $error("nmi hold");
  a_sync_a: assert property (irq_req.valid && irq_req.vector == VEC_REQ_A |->
    $past(ext_request_a, 3)) else $error("sync a");
  a_sync_e: assert property (irq_req.valid && irq_req.vector == VEC_REQ_E |->
    $past(ext_request_e, 3)) else $error("sync e");
endmodule : ext_irq_pins_asserts

//--- verification/req_source_model.sv
// Model of external request sources and a cascaded controller
`timescale 1ns/1ps
module req_source_model (
  input  wire logic       ref_clk,
  input  wire logic [5:0] cmd,
  input  wire logic       ack_a_low,
  input  wire logic       ack_b_low,
  output logic      [5:0] pins
);
  // Cascaded controller withdraws its request once acknowledged
  always_ff @(posedge ref_clk) begin
    pins <= cmd & ~{4'h0, !ack_b_low, !ack_a_low};
  end
endmodule : req_source_model

//--- verification/tb.sv
// Testbench for the external interrupt front end
`timescale 1ns/1ps
module tb;
  import ext_irq_pkg::*;
  logic ref_clk = 0, srst = 1, exp_en = 0, taken = 0, c_in, d_in, ack_a_low, ack_b_low, oe_a, oe_b;
  logic [4:0] mask = 5'h00;
  logic [5:0] cmd = 6'h00, pins;
  irq_req_t irq_req;
  int fail_count = 0, compares = 0;
  always #4 ref_clk = ~ref_clk;
  // Shared pins read back the acknowledge while it is driven
  assign c_in = oe_a ? ack_a_low : pins[2];
  assign d_in = oe_b ? ack_b_low : pins[3];
  req_source_model src (.ref_clk(ref_clk), .cmd(cmd), .ack_a_low(ack_a_low), .ack_b_low(ack_b_low), .pins(pins));
  ext_irq_pins dut (.ref_clk(ref_clk), .srst(srst), .ext_request_a(pins[0]), .ext_request_b(pins[1]),
    .ext_request_c_in(c_in), .ext_request_d_in(d_in), .ext_request_e(pins[4]), .nmi_request(pins[5]),
    .ack_a_low(ack_a_low), .ack_a_oe(oe_a), .ack_b_low(ack_b_low), .ack_b_oe(oe_b), .expansion_en(exp_en),
    .mask(mask), .irq_req(irq_req), .irq_taken(taken));
  task automatic final_report;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic waitv(input logic lvl);
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk) #1;
      if (irq_req.valid === lvl) break;
    end
    if (n == 20) begin
      fail_count++;
      $display("MISMATCH %0t wait for valid timed out", $time);
      final_report();
    end
  endtask : waitv
  task automatic t_vectors;
    logic [7:0] v [5] = '{VEC_REQ_A, VEC_REQ_B, VEC_REQ_C, VEC_REQ_D, VEC_REQ_E};
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk) cmd <= 6'h01 << i;
      waitv(1'b1);
      chk(irq_req, {2'b10, v[i]});
      @(posedge ref_clk) cmd <= 6'h00;
      waitv(1'b0);
    end
  endtask : t_vectors
  task automatic t_nmi;
    @(posedge ref_clk) begin mask <= 5'h1f; cmd <= 6'h21; end
    @(posedge ref_clk) cmd <= 6'h01;
    waitv(1'b1);
    chk(irq_req, {2'b11, VEC_NMI});
    repeat (4) @(posedge ref_clk);
    #1 chk(irq_req, {2'b11, VEC_NMI});
    @(posedge ref_clk) taken <= 1'b1;
    @(posedge ref_clk) taken <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #1 chk({9'h000, irq_req.valid}, 10'h000);
    @(posedge ref_clk) begin mask <= 5'h00; cmd <= 6'h00; end
    waitv(1'b0);
  endtask : t_nmi
  task automatic t_expand;
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk) begin exp_en <= 1'b1; cmd <= 6'h0c | (6'h01 << i); end
      waitv(1'b1);
      chk({oe_a, oe_b, irq_req.vector}, {2'b11, i[0] ? VEC_REQ_B : VEC_REQ_A});
      @(posedge ref_clk) taken <= 1'b1;
      @(posedge ref_clk) begin taken <= 1'b0; cmd <= 6'h00; end
      #1 chk({ack_a_low, ack_b_low, 8'h00}, {i[0], !i[0], 8'h00});
      @(posedge ref_clk) #1 chk({ack_a_low, ack_b_low, 8'h00}, 10'h300);
      waitv(1'b0);
    end
    repeat (6) @(posedge ref_clk);
    #1 chk({9'h000, irq_req.valid}, 10'h000);
    @(posedge ref_clk) exp_en <= 1'b0;
  endtask : t_expand
  initial begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    t_vectors();
    t_nmi();
    t_expand();
    repeat (4) @(posedge ref_clk);
    final_report();
  end
endmodule : tb
bind ext_irq_pins ext_irq_pins_asserts asserts_i (.*);
